// *** src/chg_regs.sv ***
module chg_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Decoded bus transactions
  input  wire logic                  cmd_valid,
  input  wire chg_pkg::cmd_t         cmd,
  output chg_pkg::resp_t             resp,
  // Analog comparators, asynchronous
  input  wire chg_pkg::sense_t       sense_raw,
  // Converted pin limit, same clock
  input  wire logic [6:0]            external_limit_pin,
  // Regulator controls and adapter status
  output logic      [6:0]            charge_level_code,
  output logic                       charge_enable,
  output logic                       adapter_overcurrent_trip,
  output logic                       adapter_present
);
  import chg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  sense_t     sense_s;
  logic [2:0] sense_bits;

  level_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .raw    (sense_raw),
    .synced (sense_bits)
  );

  assign sense_s = sense_t'(sense_bits);

  ////////////////////////////////////////////////////////////////////////////

  logic [6:0] level_r;
  logic [6:0] level_nxt;
  logic       inhibit_r;
  logic       inhibit_nxt;
  logic       octrip_r;
  logic       octrip_nxt;
  resp_t      resp_nxt;
  logic       bus_live;
  logic       hit_opt;
  logic       hit_lvl;
  logic       lvl_ok;
  logic [6:0] wr_code;

  // The interface is dead below lockout or with the 0.6 V comparator low.
  assign bus_live = sense_s.supply_ok && sense_s.above_0v6;
  assign hit_opt  = cmd.code == CMD_OPTIONS;
  assign hit_lvl  = cmd.code == CMD_CHG_LEVEL;
  assign wr_code  = cmd.data[LVL_MSB:LVL_LSB];
  // Any of the top three bits set means more than the top of the range.
  assign lvl_ok   = ((cmd.data & LVL_OVER_MASK) == WORD_ZERO)
                    && (wr_code >= LVL_MIN) && (wr_code <= LVL_MAX);

  always_comb begin
    level_nxt   = level_r;
    inhibit_nxt = inhibit_r;
    octrip_nxt  = octrip_r;
    resp_nxt    = RESP_RST;
    if (cmd_valid) begin
      resp_nxt.valid = 1'b1;
      if (bus_live && (hit_opt || hit_lvl)) begin
        resp_nxt.ack = 1'b1;
        if (cmd.write) begin
          if (hit_lvl) begin
            level_nxt = lvl_ok ? wr_code : LVL_RST;
          end else begin
            inhibit_nxt = cmd.data[OPT_INHIBIT];
            octrip_nxt  = cmd.data[OPT_OCTRIP];
          end
        end else if (hit_lvl) begin
          resp_nxt.data[LVL_MSB:LVL_LSB] = level_r;
        end else begin
          resp_nxt.data[OPT_INHIBIT] = inhibit_r;
          resp_nxt.data[OPT_OCTRIP]  = octrip_r;
          resp_nxt.data[OPT_ADAPTER] = adapter_present;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r   <= LVL_RST;
      inhibit_r <= OPT_INHIBIT_RST;
      octrip_r  <= OPT_OCTRIP_RST;
      resp      <= RESP_RST;
    end else begin
      level_r   <= level_nxt;
      inhibit_r <= inhibit_nxt;
      octrip_r  <= octrip_nxt;
      resp      <= resp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [6:0] eff_nxt;
  logic       en_nxt;

  // A pin held above full scale converts to the top code, so the
  // register alone then sets the level.
  always_comb begin
    eff_nxt = inhibit_r ? LVL_RST
                        : min_level(level_r, external_limit_pin);
    en_nxt  = eff_nxt != LVL_RST;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_level_code        <= LVL_RST;
      charge_enable            <= 1'b0;
      adapter_overcurrent_trip <= OPT_OCTRIP_RST;
      adapter_present          <= ADAPTER_RST;
    end else begin
      charge_level_code        <= eff_nxt;
      charge_enable            <= en_nxt;
      adapter_overcurrent_trip <= octrip_r;
      adapter_present          <= sense_s.above_2v4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_adapter_flag: assert property (
    ##1 adapter_present == $past(sense_s.above_2v4))
    else $error("adapter flag does not follow comparator");

  a_octrip_follow: assert property (
    cmd_valid && cmd.write && hit_opt && bus_live
    |=> ##1 adapter_overcurrent_trip == $past(cmd.data[OPT_OCTRIP], 2))
    else $error("trip enable not taken from option write");

  a_inhibit_gate: assert property (
    inhibit_r |=> !charge_enable && charge_level_code == LVL_RST)
    else $error("charging while inhibited");

  a_level_store: assert property (
    cmd_valid && cmd.write && hit_lvl && bus_live && lvl_ok
    |=> level_r == $past(wr_code))
    else $error("valid level not stored");

  a_range_clear: assert property (
    cmd_valid && cmd.write && hit_lvl && bus_live && !lvl_ok
    |=> level_r == LVL_RST ##1 !charge_enable)
    else $error("out of range write not cleared");

  a_zero_idle: assert property (
    level_r == LVL_RST |=> !charge_enable)
    else $error("charging with zero level");

  a_min_limit: assert property (
    !inhibit_r |=> charge_level_code <= $past(level_r)
      && charge_level_code <= $past(external_limit_pin)
      && (charge_level_code == $past(level_r)
          || charge_level_code == $past(external_limit_pin)))
    else $error("level is not the lower limit");

  a_lockout: assert property (
    cmd_valid && !bus_live |=> resp.valid && !resp.ack
      && level_r == $past(level_r))
    else $error("answered during lockout");

  a_read_back: assert property (
    cmd_valid && !cmd.write && hit_lvl && bus_live
    |=> resp.ack && resp.data[LVL_MSB:LVL_LSB] == $past(level_r)
      && resp.data[LVL_LSB-1:0] == 6'h00)
    else $error("read back differs from stored level");

  a_resp_pulse: assert property (
    !cmd_valid |=> !resp.valid)
    else $error("answer without a request");

  a_code_refuse: assert property (
    cmd_valid && !hit_opt && !hit_lvl
    |=> resp.valid && !resp.ack && resp.data == WORD_ZERO)
    else $error("unknown command code accepted");

  a_nack_quiet: assert property (
    cmd_valid && !bus_live |=> resp.data == WORD_ZERO
      && inhibit_r == $past(inhibit_r) && octrip_r == $past(octrip_r))
    else $error("refused request changed state or returned data");

  a_inhibit_take: assert property (
    cmd_valid && cmd.write && hit_opt && bus_live
    |=> inhibit_r == $past(cmd.data[OPT_INHIBIT]))
    else $error("inhibit bit not taken from option write");

  a_level_hold: assert property (
    !(cmd_valid && cmd.write && hit_lvl && bus_live)
    |=> level_r == $past(level_r))
    else $error("stored level changed without a write");

  a_level_range: assert property (
    level_r == LVL_RST || level_r >= LVL_MIN)
    else $error("stored level outside the accepted range");

  a_opt_unused: assert property (
    cmd_valid && !cmd.write && hit_opt && bus_live
    |=> resp.ack && resp.data[15:5] == 11'h000
      && resp.data[3:2] == 2'h0
      && resp.data[OPT_ADAPTER] == $past(adapter_present))
    else $error("option read shows wrong bits");

endmodule : chg_regs

// *** common/chg_pkg.sv ***
package chg_pkg;

  // Command codes of the two word registers.
  localparam logic [7:0]  CMD_OPTIONS     = 8'h12;
  localparam logic [7:0]  CMD_CHG_LEVEL   = 8'h14;

  // Charge level field, 64 mA per step with a 10 mOhm sense resistor.
  localparam int          LVL_LSB         = 6;
  localparam int          LVL_MSB         = 12;
  localparam int          LVL_W           = LVL_MSB - LVL_LSB + 1;
  localparam logic [6:0]  LVL_MIN         = 7'h02;
  localparam logic [6:0]  LVL_MAX         = 7'h7F;
  localparam logic [6:0]  LVL_RST         = 7'h00;
  localparam logic [15:0] LVL_OVER_MASK   = 16'hE000;

  // Option bits kept by this block.
  localparam int          OPT_INHIBIT     = 0;
  localparam int          OPT_OCTRIP      = 1;
  localparam int          OPT_ADAPTER     = 4;
  localparam logic        OPT_INHIBIT_RST = 1'b0;
  localparam logic        OPT_OCTRIP_RST  = 1'b1;
  localparam logic        ADAPTER_RST     = 1'b0;

  localparam int          SENSE_W         = 3;
  localparam logic [2:0]  SENSE_RST       = 3'h0;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;

  // One word transaction as delivered by the serial bus engine.
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_t;

  // Answer to a transaction, valid for one cycle.
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] data;
  } resp_t;

  // Comparator levels from the analog front end.
  typedef struct packed {
    logic supply_ok;
    logic above_0v6;
    logic above_2v4;
  } sense_t;

  localparam resp_t RESP_RST = '{valid: 1'b0, ack: 1'b0, data: 16'h0000};

  function automatic logic [6:0] min_level(input logic [6:0] a,
                                           input logic [6:0] b);
    min_level = (a < b) ? a : b;
  endfunction : min_level

endpackage : chg_pkg

// *** src/level_sync.sv ***
module level_sync (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Levels
  input  wire logic [chg_pkg::SENSE_W-1:0] raw,
  output logic      [chg_pkg::SENSE_W-1:0] synced
);
  import chg_pkg::*;

  logic [SENSE_W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= SENSE_RST;
      synced <= SENSE_RST;
    end else begin
      meta_r <= raw;
      synced <= meta_r;
    end
  end

endmodule : level_sync

// *** tb/host_model.sv ***
module host_model (
  // Clock
  input  wire logic           clk,
  // Transaction side
  output logic                cmd_valid,
  output chg_pkg::cmd_t       cmd,
  input  wire chg_pkg::resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  import chg_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // Released qualifiers are scrambled so stale values cannot pass.
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output resp_t r);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= '{write: w, code: c, data: d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd       <= cmd_t'(~cmd);
    #1 r = resp;
  endtask : xfer
endmodule : host_model

// *** tb/charge_current_and_option_regs_tb_top.sv ***
module charge_current_and_option_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import chg_pkg::*;
  logic       clk, rst_n, cmd_valid, chg_en, oc_trip, present;
  cmd_t       cmd;
  resp_t      resp, r;
  sense_t     sense_raw;
  logic [6:0] pin_code, lvl_code;
  int         n_errors, comparisons, lvl, inh, trip, pin;
  localparam logic [15:0] BND [7] = '{16'h0000, 16'h0040, 16'h0080,
    16'h1FFF, 16'h2080, 16'hFFFF, 16'h00BF};

  chg_regs i_chg_regs (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .resp(resp), .sense_raw(sense_raw),
    .external_limit_pin(pin_code), .charge_level_code(lvl_code),
    .charge_enable(chg_en), .adapter_overcurrent_trip(oc_trip),
    .adapter_present(present));
  host_model i_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .resp(resp));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Pin limit is never driven below 2, so a zero code means not charging.
  task automatic chk_out();
    int e;
    e = inh ? 0 : (lvl < pin ? lvl : pin);
    chk({lvl_code, chg_en, oc_trip}, 18'({e, e != 0, trip[0]}));
  endtask : chk_out
  task automatic xact(input logic w, input logic [7:0] c,
                      input logic [15:0] d, input logic [17:0] e);
    i_host_model.xfer(w, c, d, r);
    chk({r.valid, r.ack, r.data}, e);
    @(posedge clk);
    #1 chk_out();
  endtask : xact
  task automatic wr_lvl(input logic [15:0] d);
    lvl = (d[15:13] == 3'h0 && d[12:6] >= 7'h02) ? int'(d[12:6]) : 0;
    xact(1'b1, CMD_CHG_LEVEL, d, 18'h30000);
    xact(1'b0, CMD_CHG_LEVEL, 0, 18'h30000 | 18'(lvl << 6));
  endtask : wr_lvl
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20us;
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n     = 1'b0;
    sense_raw = '1;
    pin_code  = 7'h7F;
    pin       = 127;
    lvl       = 0;
    inh       = 0;
    trip      = 1;
    void'($urandom(68));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk_out();
    for (int a = 1; a >= 0; a--) begin
      @(posedge clk);
      sense_raw.above_2v4 <= a[0];
      repeat (4) @(posedge clk);
      #1 chk(18'(present), 18'(a));
      xact(1'b0, CMD_OPTIONS, 0, 18'h30000 | 18'(a * 16 + 2));
    end
    $display("test reset and options done");
    foreach (BND[i]) wr_lvl(BND[i]);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      pin = $urandom_range(127, 2);
      pin_code <= 7'(pin);
      wr_lvl(i[0] ? 16'($urandom) : {3'h0, 7'($urandom_range(127, 2)),
                                      6'($urandom)});
    end
    wr_lvl(16'h1000);
    $display("test level range done");
    inh = 1; trip = 0;
    xact(1'b1, CMD_OPTIONS, 16'hFFFD, 18'h30000);
    xact(1'b0, CMD_OPTIONS, 0, 18'h30001);
    inh = 0; trip = 1;
    xact(1'b1, CMD_OPTIONS, 16'h0002, 18'h30000);
    $display("test inhibit done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sense_raw <= k ? 3'b101 : 3'b011;
      repeat (4) @(posedge clk);
      xact(1'b1, CMD_CHG_LEVEL, 16'h0800, 18'h20000);
      @(posedge clk);
      sense_raw <= '1;
      repeat (4) @(posedge clk);
    end
    xact(1'b0, 8'h15, 0, 18'h20000);
    xact(1'b0, CMD_CHG_LEVEL, 0, 18'h31000);
    $display("test lockout done");
    inh  = 1;
    trip = 0;
    xact(1'b1, CMD_OPTIONS, 16'h0001, 18'h30000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lvl  = 0;
    inh  = 0;
    trip = 1;
    repeat (4) @(posedge clk);
    #1 chk_out();
    xact(1'b0, CMD_CHG_LEVEL, 0, 18'h30000);
    xact(1'b0, CMD_OPTIONS, 0, 18'h30012);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : charge_current_and_option_regs_tb_top
